// ---- hdl/cligd_pkg.sv ----
// Summary of operation
// - bits 13..0 gate levels 14..1
// - bit 15 gates realtime os irq
// - bit 14 gates data log irq
// - debug enables matter only when halted
// - halted: serve only time-critical enabled irqs
// - running emulation: ignore debug enables
// - debug enables read/write, same layout
// - debug enables via push and pop
// - reset clears debug enables
// - reset clears level enables
// - ack needs enable, pending, mask clear
// - service or software irq without trap clears enable
package cligd_pkg;
    localparam int              IRQ_W        = 16;
    localparam int              BIT_RTOS     = 15;
    localparam int              BIT_DLOG     = 14;
    localparam logic [15:0]     LVL_RST      = 16'h0000;
    localparam logic [15:0]     DBG_RST      = 16'h0000;
    localparam logic [3:0]      IDX_RST      = 4'h0;
    typedef enum logic [2:0] {
        OP_NONE  = 3'b000,
        OP_OR    = 3'b001,
        OP_AND   = 3'b010,
        OP_MOVE  = 3'b011,
        OP_POP   = 3'b100
    } cligd_op_type;
endpackage

// ---- hdl/cligd_arbiter.sv ----
`timescale 1ns/10ps
module cligd_arbiter (
    input  wire logic [15:0] cand_i,
    output logic             any_o,
    output logic [3:0]       idx_o
);
    // lowest bit number wins, as level 1 has highest priority
    always_comb begin
        any_o = 1'b0;
        idx_o = cligd_pkg::IDX_RST;
        for (int i = cligd_pkg::IRQ_W - 1; i >= 0; i--) begin
            if (cand_i[i]) begin
                any_o = 1'b1;
                idx_o = 4'(i);
            end
        end
    end
endmodule

// ---- hdl/cligd_top.sv ----
`timescale 1ns/10ps
module cligd_top (
    input  wire logic                 clock_i,
    input  wire logic                 nrst_i,
    input  wire cligd_pkg::cligd_op_type lvl_op_i,
    input  wire logic [15:0]          lvl_wdata_i,
    input  wire logic                 dbg_pop_i,
    input  wire logic [15:0]          dbg_pop_data_i,
    input  wire logic [15:0]          pending_flag_reg_i,
    input  wire logic                 global_irq_mask_i,
    input  wire logic                 emu_halted_i,
    input  wire logic                 service_i,
    input  wire logic                 software_irq_instruction_i,
    input  wire logic                 trap_i,
    input  wire logic [3:0]           sw_idx_i,
    output logic [15:0]               interrupt_level_enable_o,
    output logic [15:0]               debug_time_critical_enable_o,
    output logic                      irq_req_o,
    output logic [3:0]                irq_idx_o
);
    logic [15:0] lvl_r;
    logic [15:0] lvl_nxt;
    logic [15:0] dbg_r;
    logic [15:0] dbg_nxt;
    logic        req_r;
    logic        req_nxt;
    logic [3:0]  idx_r;
    logic [3:0]  idx_nxt;
    logic [15:0] cand;
    logic        any;
    logic [3:0]  win;

    function automatic logic [15:0] onehot(input logic [3:0] n);
        onehot = 16'h0001 << n;
    endfunction

    always_comb begin
        cand = pending_flag_reg_i & lvl_r;
        if (emu_halted_i) begin
            cand = cand & dbg_r;
        end
        if (global_irq_mask_i) begin
            cand = 16'h0000;
        end
    end

    cligd_arbiter u_arb (
        .cand_i (cand),
        .any_o  (any),
        .idx_o  (win)
    );

    always_comb begin
        lvl_nxt = lvl_r;
        unique case (lvl_op_i)
            cligd_pkg::OP_OR:   lvl_nxt = lvl_r | lvl_wdata_i;
            cligd_pkg::OP_AND:  lvl_nxt = lvl_r & lvl_wdata_i;
            cligd_pkg::OP_MOVE: lvl_nxt = lvl_wdata_i;
            cligd_pkg::OP_POP:  lvl_nxt = lvl_wdata_i;
            default:            lvl_nxt = lvl_r;
        endcase
        if (service_i && req_r) begin
            lvl_nxt = lvl_nxt & ~onehot(idx_r);
        end
        if (software_irq_instruction_i && !trap_i) begin
            lvl_nxt = lvl_nxt & ~onehot(sw_idx_i);
        end
    end

    always_comb begin
        dbg_nxt = dbg_r;
        if (dbg_pop_i) begin
            dbg_nxt = dbg_pop_data_i;
        end
    end

    always_comb begin
        req_nxt = any;
        idx_nxt = win;
        if (service_i && req_r) begin
            req_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lvl_r <= cligd_pkg::LVL_RST;
            dbg_r <= cligd_pkg::DBG_RST;
            req_r <= 1'b0;
            idx_r <= cligd_pkg::IDX_RST;
        end else begin
            lvl_r <= lvl_nxt;
            dbg_r <= dbg_nxt;
            req_r <= req_nxt;
            idx_r <= idx_nxt;
        end
    end

    assign interrupt_level_enable_o     = lvl_r;
    assign debug_time_critical_enable_o = dbg_r;
    assign irq_req_o                    = req_r;
    assign irq_idx_o                    = idx_r;

    sequence s_halted_req;
        emu_halted_i && req_r;
    endsequence

    AST_RESET_LVL: assert property (@(posedge clock_i)
        $rose(nrst_i) |-> lvl_r == 16'h0000)
        else $error("level enables not clear after reset");
    AST_RESET_DBG: assert property (@(posedge clock_i)
        $rose(nrst_i) |-> dbg_r == 16'h0000)
        else $error("debug enables not clear after reset");
    AST_REQ_ENABLED: assert property (@(posedge clock_i)
        disable iff (!nrst_i) irq_req_o |-> $past(lvl_r[irq_idx_o]))
        else $error("request on disabled level");
    AST_MASK_BLOCK: assert property (@(posedge clock_i)
        disable iff (!nrst_i) $past(global_irq_mask_i) |-> !irq_req_o)
        else $error("request while masked");
    AST_HALT_CRIT: assert property (@(posedge clock_i)
        disable iff (!nrst_i)
        s_halted_req ##0 $past(emu_halted_i)
        |-> $past(dbg_r[irq_idx_o]))
        else $error("non time-critical served while halted");
    AST_RUN_IGNORE: assert property (@(posedge clock_i)
        disable iff (!nrst_i)
        (!emu_halted_i && !global_irq_mask_i && pending_flag_reg_i[0]
         && lvl_r[0] && !(service_i && req_r))
        |=> irq_req_o && irq_idx_o == 4'h0)
        else $error("running mode blocked by debug enables");
    AST_POP_DBG: assert property (@(posedge clock_i)
        disable iff (!nrst_i)
        dbg_pop_i |=> dbg_r == $past(dbg_pop_data_i))
        else $error("pop did not load debug enables");
    AST_SVC_CLR: assert property (@(posedge clock_i)
        disable iff (!nrst_i)
        (service_i && req_r && lvl_op_i == cligd_pkg::OP_NONE)
        |=> !lvl_r[$past(idx_r)])
        else $error("serviced level enable not cleared");

    sequence s_taken;
        service_i && req_r;
    endsequence

    sequence s_req_at(logic [3:0] n);
        irq_req_o && irq_idx_o == n;
    endsequence

    sequence s_quiet_lvl;
        lvl_op_i == cligd_pkg::OP_NONE && !software_irq_instruction_i;
    endsequence

    AST_RESET_REQ: assert property (@(posedge clock_i)
        $rose(nrst_i) |-> !irq_req_o)
        else $error("request raised straight after reset");

    AST_RESET_IDX: assert property (@(posedge clock_i)
        $rose(nrst_i) |-> irq_idx_o == cligd_pkg::IDX_RST)
        else $error("request index not clear after reset");

    AST_CAND_REQ: assert property (@(posedge clock_i)
        disable iff (!nrst_i)
        (cand != 16'h0000 && !(service_i && req_r)) |=> irq_req_o)
        else $error("acceptable interrupt not requested");

    AST_NO_CAND: assert property (@(posedge clock_i)
        disable iff (!nrst_i)
        cand == 16'h0000 |=> !irq_req_o)
        else $error("request without candidate");

    AST_IDX_IDLE: assert property (@(posedge clock_i)
        disable iff (!nrst_i)
        (!irq_req_o && $past(cand == 16'h0000))
        |-> irq_idx_o == cligd_pkg::IDX_RST)
        else $error("idle request index not at rest value");

    AST_MASK_EMPTY: assert property (@(posedge clock_i)
        disable iff (!nrst_i)
        global_irq_mask_i |-> cand == 16'h0000)
        else $error("candidate present while masked");

    AST_CAND_SUB: assert property (@(posedge clock_i)
        disable iff (!nrst_i)
        (cand & ~(pending_flag_reg_i & lvl_r)) == 16'h0000)
        else $error("candidate not both enabled and pending");

    AST_HALT_SUBSET: assert property (@(posedge clock_i)
        disable iff (!nrst_i)
        emu_halted_i |-> (cand & ~dbg_r) == 16'h0000)
        else $error("non time-critical candidate while halted");

    AST_RUN_ALL: assert property (@(posedge clock_i)
        disable iff (!nrst_i)
        (!emu_halted_i && !global_irq_mask_i)
        |-> cand == (pending_flag_reg_i & lvl_r))
        else $error("debug enables used while running");

    AST_SVC_DROP: assert property (@(posedge clock_i)
        disable iff (!nrst_i)
        s_taken |=> !irq_req_o)
        else $error("request stayed after being taken");

    AST_SWI_CLR: assert property (@(posedge clock_i)
        disable iff (!nrst_i)
        (software_irq_instruction_i && !trap_i) |=> !lvl_r[$past(sw_idx_i)])
        else $error("software irq left its enable set");

    AST_TRAP_KEEP: assert property (@(posedge clock_i)
        disable iff (!nrst_i)
        (software_irq_instruction_i && trap_i
         && lvl_op_i == cligd_pkg::OP_NONE && !(service_i && req_r))
        |=> $stable(lvl_r))
        else $error("trap request changed level enables");

    AST_LVL_OR: assert property (@(posedge clock_i)
        disable iff (!nrst_i)
        (lvl_op_i == cligd_pkg::OP_OR && !(service_i && req_r)
         && !software_irq_instruction_i)
        |=> lvl_r == $past(lvl_r | lvl_wdata_i))
        else $error("or operation gave wrong level enables");

    AST_LVL_AND: assert property (@(posedge clock_i)
        disable iff (!nrst_i)
        (lvl_op_i == cligd_pkg::OP_AND && !(service_i && req_r)
         && !software_irq_instruction_i)
        |=> lvl_r == $past(lvl_r & lvl_wdata_i))
        else $error("and operation gave wrong level enables");

    AST_LVL_MOVE: assert property (@(posedge clock_i)
        disable iff (!nrst_i)
        (lvl_op_i inside {cligd_pkg::OP_MOVE, cligd_pkg::OP_POP}
         && !(service_i && req_r) && !software_irq_instruction_i)
        |=> lvl_r == $past(lvl_wdata_i))
        else $error("load operation gave wrong level enables");

    AST_LVL_HOLD: assert property (@(posedge clock_i)
        disable iff (!nrst_i)
        s_quiet_lvl ##0 !(service_i && req_r) |=> $stable(lvl_r))
        else $error("level enables changed while idle");

    AST_DBG_HOLD: assert property (@(posedge clock_i)
        disable iff (!nrst_i)
        !dbg_pop_i |=> $stable(dbg_r))
        else $error("debug enables changed without pop");

    for (genvar g = 0; g < cligd_pkg::IRQ_W; g++) begin : g_lvl
        // lower-numbered levels outrank level g
        localparam logic [15:0] LOWER = 16'((32'h1 << g) - 32'h1);

        AST_BIT_GATE: assert property (@(posedge clock_i)
            disable iff (!nrst_i)
            s_req_at(4'(g))
            |-> $past(lvl_r[g] && pending_flag_reg_i[g]))
            else $error("level requested while disabled or idle");

        AST_BIT_HALT: assert property (@(posedge clock_i)
            disable iff (!nrst_i)
            s_req_at(4'(g)) ##0 $past(emu_halted_i)
            |-> $past(dbg_r[g]))
            else $error("halted request on non time-critical level");

        AST_BIT_PRIO: assert property (@(posedge clock_i)
            disable iff (!nrst_i)
            s_req_at(4'(g)) |-> $past(cand & LOWER) == 16'h0000)
            else $error("request skipped a lower-numbered level");

        AST_BIT_WIN: assert property (@(posedge clock_i)
            disable iff (!nrst_i)
            (cand[g] && (cand & LOWER) == 16'h0000
             && !(service_i && req_r)) |=> s_req_at(4'(g)))
            else $error("winning level not requested");

        AST_BIT_SWI: assert property (@(posedge clock_i)
            disable iff (!nrst_i)
            (software_irq_instruction_i && !trap_i && sw_idx_i == 4'(g))
            |=> !lvl_r[g])
            else $error("software irq left this level enabled");

        AST_BIT_POP: assert property (@(posedge clock_i)
            disable iff (!nrst_i)
            dbg_pop_i |=> dbg_r[g] == $past(dbg_pop_data_i[g]))
            else $error("pop left a debug enable bit wrong");
    end
endmodule

// ---- testbench/cligd_cpu_model.sv ----
`timescale 1ns/10ps
module cligd_cpu_model (
    input  wire logic clock_i,
    input  wire logic nrst_i,
    input  wire logic ack_en_i,
    input  wire logic irq_req_i,
    output logic      service_o
);
    always @(negedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            service_o <= 1'b0;
        end else begin
            service_o <= ack_en_i && irq_req_i && !service_o;
        end
    end
endmodule

// ---- testbench/tb.sv ----
`timescale 1ns/10ps
module tb;
    logic                    clock_i = 0, nrst_i = 0, pop = 0, mask = 0;
    logic                    halt = 0, ack = 0, swi = 0, trap = 0, svc, req;
    cligd_pkg::cligd_op_type op = cligd_pkg::OP_NONE;
    logic [15:0]             wd = 16'h0000, pd = 16'h0000, pend = 16'h0000;
    logic [15:0]             lvl, dbg;
    logic [3:0]              sidx = 4'h0, idx;
    int                      miscompares = 0, num_checks = 0, cyc = 0;
    initial forever #2 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 2000) begin
            miscompares++;
            conclude();
        end
    end
    cligd_top u_cligd_top (.clock_i(clock_i), .nrst_i(nrst_i), .lvl_op_i(op),
        .lvl_wdata_i(wd), .dbg_pop_i(pop), .dbg_pop_data_i(pd),
        .pending_flag_reg_i(pend), .global_irq_mask_i(mask),
        .emu_halted_i(halt), .service_i(svc),
        .software_irq_instruction_i(swi), .trap_i(trap), .sw_idx_i(sidx),
        .interrupt_level_enable_o(lvl), .debug_time_critical_enable_o(dbg),
        .irq_req_o(req), .irq_idx_o(idx));
    cligd_cpu_model u_cligd_cpu_model (.clock_i(clock_i), .nrst_i(nrst_i),
        .ack_en_i(ack), .irq_req_i(req), .service_o(svc));
    task tick(input int n);
        repeat (n) @(negedge clock_i);
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %0t got %h exp %h", $time, g, e);
        end
    endtask
    task lop(input cligd_pkg::cligd_op_type o, input logic [15:0] d);
        op = o;
        wd = d;
        tick(1);
        op = cligd_pkg::OP_NONE;
    endtask
    // pending flags in, then request and index out
    task rchk(input logic [15:0] p, input logic [4:0] e);
        pend = p;
        tick(3);
        chk({11'h000, req, idx}, {11'h000, e});
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        tick(5);
        nrst_i = 1;
        tick(1);
        chk(lvl, 16'h0000);
        chk(dbg, 16'h0000);
        pop = 1;
        pd = 16'h0001;
        tick(1);
        pop = 0;
        chk(dbg, 16'h0001);
        $display("reset and pop done");
        lop(cligd_pkg::OP_MOVE, 16'h0001);
        lop(cligd_pkg::OP_OR, 16'hc000);
        lop(cligd_pkg::OP_AND, 16'hc00f);
        chk(lvl, 16'hc001);
        rchk(16'h4000, 5'h1e);
        rchk(16'h8000, 5'h1f);
        rchk(16'h0002, 5'h00);
        mask = 1;
        rchk(16'h0001, 5'h00);
        mask = 0;
        $display("level gating done");
        halt = 1;
        rchk(16'h4000, 5'h00);
        rchk(16'h4001, 5'h10);
        halt = 0;
        rchk(16'h4000, 5'h1e);
        $display("debug gating done");
        trap = 1;
        swi = 1;
        sidx = 4'he;
        tick(1);
        swi = 0;
        chk(lvl, 16'hc001);
        trap = 0;
        swi = 1;
        tick(1);
        swi = 0;
        chk(lvl, 16'h8001);
        pend = 16'h0001;
        ack = 1;
        tick(4);
        ack = 0;
        chk(lvl, 16'h8000);
        $display("clearing done");
        lop(cligd_pkg::OP_POP, 16'h1234);
        chk(lvl, 16'h1234);
        conclude();
    end
endmodule
